//--- logic/sfc_flow_ctrl.sv
/*
 * Flow control for the asynchronous serial port: request/clear-to-send lines,
 * optional stop/resume characters both ways, terminal-ready line.
 * Assumes a character receiver and transmitter around it that do the framing
 * and baud timing from their own rate; characters arrive and leave as bytes.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - With software handshaking on, a stop character 19 is sent once the receive side is full.
// - After a stop character, a resume character 17 is sent once receiving is possible again.
// - With software handshaking on, a received stop halts data sending until a resume arrives.
// - Request-to-send is high whenever the block can take serial data from the host.
// - Request-to-send drops when the receive side is full, and the host must then hold off.
// - Data goes out only while clear-to-send is high and stops whenever it drops.
// - Terminal-ready goes high once the block is out of reset and ready to work.
// - The block is terminal equipment: it sends on transmit data and takes on receive data.
// - The link is asynchronous, each side timing characters from its own baud rate.
// - A setting turns software handshaking on or off; the line handshake is always active.
module sfc_flow_ctrl
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Configuration
    input wire logic sw_hs_en,
    // Modem lines
    output logic rts_out,
    input wire logic cts_in,
    output logic dtr_out,
    // Characters from the serial receiver
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char_data,
    // Toward the receive buffer memory
    output logic rxb_wr_valid,
    output logic [7:0] rxb_wr_data,
    input wire logic rxb_wr_ready,
    input wire logic rxb_full,
    // Data to send, from the instrument side
    input wire logic tx_in_valid,
    input wire logic [7:0] tx_in_data,
    output logic tx_in_ready,
    // Characters to the serial transmitter
    output logic txr_valid,
    output logic [7:0] txr_data,
    input wire logic txr_ready,
    // Status
    output logic rx_overrun
);

    // ****************************************
    // Declarations
    // ****************************************
    sfc_pkg::sfc_fc_type fc_state_ff, nxt_fc_state;
    logic paused_ff, nxt_paused;
    logic hold_valid_ff, nxt_hold_valid;
    logic hold_ctrl_ff, nxt_hold_ctrl;
    logic [7:0] hold_data_ff, nxt_hold_data;
    logic txr_valid_ff, nxt_txr_valid;
    logic [7:0] txr_data_ff, nxt_txr_data;
    logic tx_in_ready_ff, nxt_tx_in_ready;
    logic rts_ff, nxt_rts;
    logic overrun_ff, nxt_overrun;
    logic dev_ready;
    logic buf_in_valid, buf_in_ready;
    logic rx_full, is_hs_char;
    logic data_take, ctrl_take, tx_fire, ctrl_due, nxt_ctrl_due;

    // ****************************************
    // Power-on ready and receive buffering
    // ****************************************
    sfc_ready_gen i_sfc_ready_gen
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ready(dev_ready)
    );

    // Two entries absorb the receiver while the buffer memory stalls
    sfc_pair_buf i_sfc_pair_buf
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_valid(buf_in_valid),
        .in_data(rx_char_data),
        .in_ready(buf_in_ready),
        .out_valid(rxb_wr_valid),
        .out_data(rxb_wr_data),
        .out_ready(rxb_wr_ready)
    );

    // ****************************************
    // Receive side
    // ****************************************
    // Full means no room in memory or in the small buffer ahead of it
    always_comb
    begin
        rx_full = rxb_full || !buf_in_ready;
        is_hs_char = sw_hs_en && sfc_pkg::sfc_is_flow_code(rx_char_data);
        buf_in_valid = rx_char_valid && !is_hs_char;
        // A serial byte cannot wait, so a byte with no room is flagged lost
        nxt_overrun = buf_in_valid && !buf_in_ready;
        nxt_paused = paused_ff;
        if (!sw_hs_en)
        begin
            nxt_paused = 1'b0;
        end
        else if (rx_char_valid && rx_char_data == sfc_pkg::STOP_CODE)
        begin
            nxt_paused = 1'b1;
        end
        else if (rx_char_valid && rx_char_data == sfc_pkg::RESUME_CODE)
        begin
            nxt_paused = 1'b0;
        end
        nxt_rts = dev_ready && !rx_full;
    end

    // ****************************************
    // Software handshake state
    // ****************************************
    // The pending character is dropped if the condition clears before it is loaded into the holding stage
    always_comb
    begin
        tx_fire = txr_valid_ff && txr_ready;
        data_take = tx_in_ready_ff && tx_in_valid;
        ctrl_due = sw_hs_en && (fc_state_ff == sfc_pkg::FC_STOP_DUE ||
                                fc_state_ff == sfc_pkg::FC_RESUME_DUE);
        ctrl_take = !hold_valid_ff && ctrl_due && !data_take;
        nxt_fc_state = fc_state_ff;
        if (!sw_hs_en)
        begin
            nxt_fc_state = sfc_pkg::FC_OPEN;
        end
        else
        begin
            case (fc_state_ff)
                sfc_pkg::FC_OPEN:
                begin
                    if (rx_full)
                    begin
                        nxt_fc_state = sfc_pkg::FC_STOP_DUE;
                    end
                end
                sfc_pkg::FC_STOP_DUE:
                begin
                    if (ctrl_take)
                    begin
                        nxt_fc_state = sfc_pkg::FC_HELD;
                    end
                    else if (!rx_full)
                    begin
                        nxt_fc_state = sfc_pkg::FC_OPEN;
                    end
                end
                sfc_pkg::FC_HELD:
                begin
                    if (!rx_full)
                    begin
                        nxt_fc_state = sfc_pkg::FC_RESUME_DUE;
                    end
                end
                sfc_pkg::FC_RESUME_DUE:
                begin
                    if (ctrl_take)
                    begin
                        nxt_fc_state = sfc_pkg::FC_OPEN;
                    end
                    else if (rx_full)
                    begin
                        nxt_fc_state = sfc_pkg::FC_HELD;
                    end
                end
                default:
                begin
                    nxt_fc_state = sfc_pkg::FC_OPEN;
                end
            endcase
        end
        nxt_ctrl_due = sw_hs_en && (nxt_fc_state == sfc_pkg::FC_STOP_DUE ||
                                    nxt_fc_state == sfc_pkg::FC_RESUME_DUE);
    end

    // ****************************************
    // Transmit side
    // ****************************************
    // One holding stage; a data word taken in the same cycle wins over a due handshake character
    always_comb
    begin
        nxt_hold_valid = hold_valid_ff;
        nxt_hold_ctrl = hold_ctrl_ff;
        nxt_hold_data = hold_data_ff;
        if (tx_fire)
        begin
            nxt_hold_valid = 1'b0;
        end
        if (data_take)
        begin
            nxt_hold_valid = 1'b1;
            nxt_hold_ctrl = 1'b0;
            nxt_hold_data = tx_in_data;
        end
        else if (ctrl_take)
        begin
            nxt_hold_valid = 1'b1;
            nxt_hold_ctrl = 1'b1;
            nxt_hold_data = (fc_state_ff == sfc_pkg::FC_STOP_DUE) ?
                            sfc_pkg::STOP_CODE : sfc_pkg::RESUME_CODE;
        end
        nxt_txr_valid = hold_valid_ff && !tx_fire && cts_in &&
                        (hold_ctrl_ff || !paused_ff);
        nxt_txr_data = hold_data_ff;
        // Registered ready is a promise: a word offered against it is always taken
        nxt_tx_in_ready = !nxt_hold_valid && !nxt_ctrl_due;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            fc_state_ff <= sfc_pkg::FC_OPEN;
            paused_ff <= 1'b0;
            hold_valid_ff <= 1'b0;
            hold_ctrl_ff <= 1'b0;
            hold_data_ff <= 8'h00;
            txr_valid_ff <= 1'b0;
            txr_data_ff <= 8'h00;
            tx_in_ready_ff <= 1'b0;
            rts_ff <= sfc_pkg::RTS_RESET;
            overrun_ff <= 1'b0;
        end
        else
        begin
            fc_state_ff <= nxt_fc_state;
            paused_ff <= nxt_paused;
            hold_valid_ff <= nxt_hold_valid;
            hold_ctrl_ff <= nxt_hold_ctrl;
            hold_data_ff <= nxt_hold_data;
            txr_valid_ff <= nxt_txr_valid;
            txr_data_ff <= nxt_txr_data;
            tx_in_ready_ff <= nxt_tx_in_ready;
            rts_ff <= nxt_rts;
            overrun_ff <= nxt_overrun;
        end
    end

    // Outputs straight from flops; framing lines live in the transmitter
    // no link clock, baud timing outside
    assign rts_out = rts_ff;
    assign dtr_out = dev_ready;
    assign txr_valid = txr_valid_ff;
    assign txr_data = txr_data_ff;
    assign tx_in_ready = tx_in_ready_ff;
    assign rx_overrun = overrun_ff;

    // ****************************************
    // Checks
    // ****************************************
    stop_due_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        sw_hs_en && fc_state_ff == sfc_pkg::FC_OPEN && rx_full
        |=> fc_state_ff == sfc_pkg::FC_STOP_DUE)
        else $error("stop not scheduled on full");
    stop_char_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ctrl_take && fc_state_ff == sfc_pkg::FC_STOP_DUE
        |=> hold_ctrl_ff && hold_data_ff == sfc_pkg::STOP_CODE)
        else $error("stop character not loaded");
    resume_due_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        sw_hs_en && fc_state_ff == sfc_pkg::FC_HELD && !rx_full
        |=> fc_state_ff == sfc_pkg::FC_RESUME_DUE ##0 ctrl_due)
        else $error("resume not scheduled");
    pause_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        sw_hs_en && rx_char_valid && rx_char_data == sfc_pkg::STOP_CODE
        |=> paused_ff)
        else $error("stop from host ignored");
    paused_tx_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        paused_ff && !hold_ctrl_ff |=> !txr_valid_ff)
        else $error("data sent while paused");
    cts_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !cts_in |=> !txr_valid_ff)
        else $error("sent without clear-to-send");
    rts_full_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        rx_full |=> !rts_out)
        else $error("request-to-send kept while full");
    rts_ready_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        dev_ready && !rx_full |=> rts_out)
        else $error("request-to-send low while able");
    dtr_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        dtr_out |=> dtr_out [*3])
        else $error("ready line fell");
    code_drop_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        sw_hs_en && rx_char_valid && sfc_pkg::sfc_is_flow_code(rx_char_data) &&
        !rxb_wr_valid |=> !rxb_wr_valid)
        else $error("handshake byte buffered");
    sw_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !sw_hs_en |=> fc_state_ff == sfc_pkg::FC_OPEN && !paused_ff)
        else $error("handshake state kept while disabled");

endmodule // sfc_flow_ctrl

`default_nettype wire

//--- logic/sfc_pkg.sv
/*
 * Shared constants, types and decoding for the serial flow-control block.
 * Assumes one system clock at 100 MHz and a synchronous active-low reset.
 */
`default_nettype none

package sfc_pkg;

    // ****************************************
    // Character codes and widths
    // ****************************************
    localparam int CHAR_W = 8;
    localparam logic [7:0] RESUME_CODE = 8'h11;
    localparam logic [7:0] STOP_CODE = 8'h13;
    localparam int BUF_DEPTH = 2;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    // Settle time before the ready line goes up
    localparam int SETTLE_NS = 200;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] SETTLE_LAST = 6'(SETTLE_CYCLES);

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RTS_RESET = 1'b0;
    localparam logic DTR_RESET = 1'b0;

    // Receive-side flow state for software handshaking
    typedef enum logic [1:0] {FC_OPEN, FC_STOP_DUE, FC_HELD, FC_RESUME_DUE} sfc_fc_type;

    // True for either handshake character
    function automatic logic sfc_is_flow_code(input logic [7:0] c);
        return (c == STOP_CODE) || (c == RESUME_CODE);
    endfunction

endpackage

`default_nettype wire

//--- logic/sfc_pair_buf.sv
/*
 * Two-entry buffer with valid and ready on both sides, all outputs registered.
 * Assumes the filler honours in_ready and the drainer may stall at will.
 */
`timescale 1ns/1ps
`default_nettype none

module sfc_pair_buf
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Filling side
    input wire logic in_valid,
    input wire logic [sfc_pkg::CHAR_W-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [sfc_pkg::CHAR_W-1:0] out_data,
    input wire logic out_ready
);

    logic [sfc_pkg::CHAR_W-1:0] slot_ff [0:sfc_pkg::BUF_DEPTH-1];
    logic [sfc_pkg::CHAR_W-1:0] nxt_slot [0:sfc_pkg::BUF_DEPTH-1];
    logic [1:0] cnt_ff, nxt_cnt;
    logic in_ready_ff, nxt_in_ready;
    logic out_valid_ff, nxt_out_valid;
    logic push, pop;

    // ****************************************
    // Next state: pop shifts toward slot 0
    // ****************************************
    always_comb
    begin
        push = in_valid && in_ready_ff;
        pop = out_valid_ff && out_ready;
        nxt_slot = slot_ff;
        nxt_cnt = cnt_ff;
        if (pop)
        begin
            nxt_slot[0] = slot_ff[1];
            nxt_cnt = cnt_ff - 2'h1;
        end
        if (push)
        begin
            nxt_slot[nxt_cnt[0]] = in_data;
            nxt_cnt = nxt_cnt + 2'h1;
        end
        // Ready is registered, so it reflects the count of next cycle
        nxt_in_ready = (nxt_cnt != 2'(sfc_pkg::BUF_DEPTH));
        nxt_out_valid = (nxt_cnt != 2'h0);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            cnt_ff <= 2'h0;
            in_ready_ff <= 1'b0;
            out_valid_ff <= 1'b0;
            slot_ff[0] <= 8'h00;
            slot_ff[1] <= 8'h00;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            in_ready_ff <= nxt_in_ready;
            out_valid_ff <= nxt_out_valid;
            slot_ff <= nxt_slot;
        end
    end

    assign in_ready = in_ready_ff;
    assign out_valid = out_valid_ff;
    assign out_data = slot_ff[0];

endmodule // sfc_pair_buf

`default_nettype wire

//--- logic/sfc_ready_gen.sv
/*
 * Power-on ready generator: raises the ready level a fixed settle time after reset.
 * Assumes reset is held while supplies come up.
 */
`timescale 1ns/1ps
`default_nettype none

module sfc_ready_gen
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Ready level
    output logic ready
);

    logic [5:0] cnt_ff, nxt_cnt;
    logic ready_ff, nxt_ready;

    // Count up once, then stay ready until the next reset
    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (cnt_ff != sfc_pkg::SETTLE_LAST)
        begin
            nxt_cnt = cnt_ff + 6'h01;
        end
        nxt_ready = (cnt_ff == sfc_pkg::SETTLE_LAST);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            cnt_ff <= 6'h00;
            ready_ff <= sfc_pkg::DTR_RESET;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            ready_ff <= nxt_ready;
        end
    end

    assign ready = ready_ff;

endmodule // sfc_ready_gen

`default_nettype wire

//--- tb/sfc_host_model.sv
/*
 * Behavioural serial host on the far side of the flow-control block.
 * Assumes the bench sets cts_lvl and slow, and calls send_byte at a falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Serial host model
// ****************************************
module sfc_host_model
(
    // Clock
    input wire logic clk_sys,
    // Modem lines
    input wire logic rts_out,
    output logic cts_in,
    // Characters toward the block
    output logic rx_char_valid,
    output logic [7:0] rx_char_data,
    // Characters from the block
    input wire logic txr_valid,
    input wire logic [7:0] txr_data,
    output logic txr_ready
);
    logic cts_lvl = 1'b0;
    logic slow = 1'b0;
    logic [7:0] got_q[$];

    // Idle lines at time zero; modem lines follow at the first falling edge
    // no link clock
    initial
    begin
        rx_char_valid = 1'b0;
        rx_char_data = 8'h00;
    end

    // Collect every character the block hands over
    always @(posedge clk_sys)
    begin
        if (txr_valid === 1'b1 && txr_ready === 1'b1)
            got_q.push_back(txr_data);
    end

    always @(negedge clk_sys)
    begin
        cts_in <= cts_lvl;
        txr_ready <= slow ? ~txr_ready : 1'b1;
    end

    task automatic send_byte(input logic [7:0] b, input bit ignore_rts);
        int n;
        n = 0;
        while (!ignore_rts && rts_out !== 1'b1 && n < 300)
        begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        rx_char_valid = 1'b1;
        rx_char_data = b;
        @(negedge clk_sys);
        rx_char_valid = 1'b0;
        // Released line shows no stale byte
        rx_char_data = ~b;
    endtask
endmodule // sfc_host_model

`default_nettype wire

//--- tb/sfc_flow_ctrl_tb_top.sv
/*
 * Self-checking bench for the serial flow-control block.
 * Assumes the package, design files and host model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Bench top
// ****************************************
module sfc_flow_ctrl_tb_top;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic sw_hs_en = 1'b0;
    logic rxb_wr_ready = 1'b1;
    logic rxb_full = 1'b0;
    logic tx_in_valid = 1'b0;
    logic [7:0] tx_in_data = 8'h00;
    logic rts_out, cts_in, dtr_out, rx_char_valid, rxb_wr_valid;
    logic tx_in_ready, txr_valid, txr_ready, rx_overrun;
    logic [7:0] rx_char_data, rxb_wr_data, txr_data;
    logic [7:0] rx_got[$];
    logic ovr_seen = 1'b0;
    int fails = 0;
    int check_count = 0;

    always #5 clk_sys = ~clk_sys;

    sfc_flow_ctrl i_sfc_flow_ctrl (.clk_sys(clk_sys), .nrst(nrst), .sw_hs_en(sw_hs_en),
        .rts_out(rts_out), .cts_in(cts_in), .dtr_out(dtr_out),
        .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
        .rxb_wr_valid(rxb_wr_valid), .rxb_wr_data(rxb_wr_data), .rxb_wr_ready(rxb_wr_ready),
        .rxb_full(rxb_full), .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
        .tx_in_ready(tx_in_ready), .txr_valid(txr_valid), .txr_data(txr_data),
        .txr_ready(txr_ready), .rx_overrun(rx_overrun));

    sfc_host_model i_sfc_host_model (.clk_sys(clk_sys), .rts_out(rts_out), .cts_in(cts_in),
        .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
        .txr_valid(txr_valid), .txr_data(txr_data), .txr_ready(txr_ready));

    // Words taken by the receive memory, and lost-word pulses
    always @(posedge clk_sys)
    begin
        if (rxb_wr_valid === 1'b1 && rxb_wr_ready === 1'b1)
            rx_got.push_back(rxb_wr_data);
        if (rx_overrun === 1'b1)
            ovr_seen = 1'b1;
    end

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Bounded wait for the next byte at the host or at the memory
    task automatic pop(input bit at_host, output logic [7:0] b);
        int n;
        n = 0;
        while (n < 300 && (at_host ? i_sfc_host_model.got_q.size() : rx_got.size()) == 0)
        begin
            cyc(1);
            n++;
        end
        b = 8'hxx;
        if (at_host && i_sfc_host_model.got_q.size() != 0)
            b = i_sfc_host_model.got_q.pop_front();
        if (!at_host && rx_got.size() != 0)
            b = rx_got.pop_front();
    endtask

    // Offer one byte; held until ready is seen before an edge
    task automatic send_tx(input logic [7:0] b);
        int n;
        n = 0;
        tx_in_valid = 1'b1;
        tx_in_data = b;
        while (tx_in_ready !== 1'b1 && n < 300)
        begin
            cyc(1);
            n++;
        end
        cyc(1);
        tx_in_valid = 1'b0;
        tx_in_data = ~b;
    endtask

    task automatic t_power;
        cyc(sfc_pkg::SETTLE_CYCLES);
        cmp_bit(dtr_out, 1'b0);
        cmp_bit(rts_out, 1'b0);
        cyc(1);
        cmp_bit(dtr_out, 1'b1);
        cyc(1);
        cmp_bit(rts_out, 1'b1);
    endtask

    // Handshake codes pass as data when the setting is off
    task automatic t_rx_plain;
        logic [7:0] b;
        logic [7:0] codes [3];
        codes = '{8'h41, 8'h11, 8'h13};
        sw_hs_en = 1'b0;
        for (int i = 0; i < 3; i++)
            i_sfc_host_model.send_byte(codes[i], 1'b0);
        for (int i = 0; i < 3; i++)
        begin
            pop(1'b0, b);
            cmp_byte(b, codes[i]);
        end
    endtask

    task automatic t_rx_hs;
        logic [7:0] b;
        sw_hs_en = 1'b1;
        i_sfc_host_model.send_byte(8'h41, 1'b0);
        i_sfc_host_model.send_byte(8'h13, 1'b0);
        i_sfc_host_model.send_byte(8'h11, 1'b0);
        i_sfc_host_model.send_byte(8'h42, 1'b0);
        pop(1'b0, b);
        cmp_byte(b, 8'h41);
        pop(1'b0, b);
        cmp_byte(b, 8'h42);
        cmp_byte(8'(rx_got.size()), 8'h00);
    endtask

    task automatic t_stop_resume;
        logic [7:0] b;
        rxb_full = 1'b1;
        cyc(3);
        cmp_bit(rts_out, 1'b0);
        cmp_bit(tx_in_ready, 1'b0);
        pop(1'b1, b);
        cmp_byte(b, 8'h13);
        rxb_full = 1'b0;
        cyc(3);
        cmp_bit(rts_out, 1'b1);
        pop(1'b1, b);
        cmp_byte(b, 8'h11);
    endtask

    // Slow host also stalls the transmitter here
    task automatic t_tx_cts;
        logic [7:0] b;
        sw_hs_en = 1'b0;
        i_sfc_host_model.cts_lvl = 1'b0;
        i_sfc_host_model.slow = 1'b1;
        send_tx(8'h55);
        cyc(10);
        cmp_byte(8'(i_sfc_host_model.got_q.size()), 8'h00);
        i_sfc_host_model.cts_lvl = 1'b1;
        pop(1'b1, b);
        cmp_byte(b, 8'h55);
        i_sfc_host_model.slow = 1'b0;
    endtask

    task automatic t_pause;
        logic [7:0] b;
        sw_hs_en = 1'b1;
        i_sfc_host_model.send_byte(8'h13, 1'b0);
        send_tx(8'h66);
        cyc(10);
        cmp_byte(8'(i_sfc_host_model.got_q.size()), 8'h00);
        i_sfc_host_model.send_byte(8'h11, 1'b0);
        pop(1'b1, b);
        cmp_byte(b, 8'h66);
    endtask

    // Memory stalls, host ignores the line: third byte is refused
    task automatic t_overrun;
        logic [7:0] b;
        sw_hs_en = 1'b0;
        rxb_wr_ready = 1'b0;
        ovr_seen = 1'b0;
        for (int i = 0; i < 3; i++)
            i_sfc_host_model.send_byte(8'h21 + 8'(i), 1'b1);
        cyc(2);
        cmp_bit(ovr_seen, 1'b1);
        cmp_bit(rts_out, 1'b0);
        rxb_wr_ready = 1'b1;
        pop(1'b0, b);
        cmp_byte(b, 8'h21);
        pop(1'b0, b);
        cmp_byte(b, 8'h22);
        cyc(5);
        cmp_byte(8'(rx_got.size()), 8'h00);
        cmp_bit(rts_out, 1'b1);
    endtask

    task automatic give_verdict;
        $display("checks made %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        cyc(6);
        nrst = 1'b1;
        t_power();
        i_sfc_host_model.cts_lvl = 1'b1;
        t_rx_plain();
        t_rx_hs();
        t_stop_resume();
        t_tx_cts();
        t_pause();
        t_overrun();
        give_verdict();
    end

    // Watchdog: tests need a few hundred cycles at most, this allows ten thousand
    initial
    begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule // sfc_flow_ctrl_tb_top

`default_nettype wire
